/* File: rtl/fsg_pkg.sv */
// Package with constants and carrier types for the flash security access guard
package fsg_pkg;

  localparam int ADDR_W    = 16;
  localparam int PAGE_BITS = 9;
  localparam int PAGE_W    = ADDR_W - PAGE_BITS;

  localparam logic [7:0] KEY_FIRST   = 8'hA5;
  localparam logic [7:0] KEY_SECOND  = 8'hF1;
  localparam logic [7:0] LOCK_ERASED = 8'hFF;

  localparam logic [7:0] OFS_PROG_STORE_CTL = 8'h00;
  localparam logic [7:0] OFS_LOCK_KEY       = 8'h04;
  localparam logic [7:0] OFS_RESET_SOURCE   = 8'h08;
  localparam logic [7:0] OFS_LOCK_STATUS    = 8'h0C;

  localparam int BIT_STORE_WRITE_EN = 0;
  localparam int BIT_STORE_ERASE_EN = 1;
  localparam int BIT_POWER_ON_FLAG  = 0;
  localparam int BIT_FLASH_ERR_FLAG = 1;
  localparam int BIT_ANY_LOCKED     = 16;

  localparam logic RST_STORE_WRITE_EN = 1'b0;
  localparam logic RST_STORE_ERASE_EN = 1'b0;

  typedef enum logic [2:0] {
    OP_CODE_READ,
    OP_EXT_READ,
    OP_EXT_WRITE,
    OP_DBG_READ,
    OP_DBG_WRITE,
    OP_DBG_ERASE,
    OP_DBG_DEV_ERASE
  } fsg_op_e;

  typedef enum logic [1:0] {
    FL_READ,
    FL_WRITE,
    FL_PAGE_ERASE,
    FL_DEV_ERASE
  } fsg_fl_e;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_HALF,
    KEY_OPEN,
    KEY_DEAD
  } fsg_key_e;

  typedef struct packed {
    fsg_op_e           op;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fsg_req_s;

  typedef struct packed {
    logic              valid;
    fsg_fl_e           kind;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fsg_fcmd_s;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fsg_external_data_ram_s;

endpackage

/* File: rtl/fsg_access_guard.sv */
// Flash security access guard with APB register slave
`timescale 1ns/100ps
module fsg_access_guard
  import fsg_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LOCK_ADDR = 16'h3DFF,
  parameter logic [ADDR_W-1:0] RSV_BASE  = 16'h3E00
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RESETN,
  input  wire logic              I_POR_N,
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [7:0]        I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic      [31:0]       O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  input  wire logic [7:0]        I_LOCK_BYTE,
  input  wire logic [ADDR_W-1:0] I_PC,
  input  wire logic              I_REQ_VALID,
  input  wire fsg_req_s          I_REQ,
  output logic                   O_REQ_READY,
  input  wire logic              I_FL_BUSY,
  output fsg_fcmd_s              O_FL_CMD,
  output fsg_external_data_ram_s              O_EXTERNAL_DATA_RAM,
  output logic                   O_DROP,
  output logic                   O_ERR_RESET,
  output logic                   O_IRQ_HOLD
);

  logic      swe_q;
  logic      see_q;
  fsg_key_e  key_q;
  logic      por_q;
  logic      ferr_q;
  logic      sampled_q;
  logic      halt_q;
  logic      ready_q;
  logic [7:0] lock_q;
  logic [7:0] lock_cur_q;
  logic [31:0] prdata_q;
  logic      pready_q;
  logic      pslverr_q;
  fsg_fcmd_s fcmd_q;
  fsg_external_data_ram_s external_data_ram_q;
  logic      drop_q;
  logic      err_q;
  logic      irq_hold_q;

  logic      req_dbg;
  logic      flash_op;
  logic      is_wr;
  logic      is_er;
  logic      is_dev;
  logic      bad;
  logic      fw_locked;
  logic      any_locked;
  logic      rsv;
  logic      on_lock_pg;
  logic      need_key;
  logic      key_ok;
  logic      take;
  logic      issue;
  logic      err_now;
  fsg_fl_e   fl_kind;
  logic      apb_acc;
  logic      apb_wr;
  logic      mapped;
  logic [31:0] rd_mux;
  logic      mod_pend;

  function automatic logic page_locked(input logic [ADDR_W-1:0] a, input logic [7:0] lk);
    logic [7:0] cnt;
    cnt = ~lk;
    page_locked = (8'(a[ADDR_W-1:PAGE_BITS]) < cnt) ||
                  ((a[ADDR_W-1:PAGE_BITS] == LOCK_ADDR[ADDR_W-1:PAGE_BITS]) &&
                   (lk != LOCK_ERASED));
  endfunction

  assign any_locked = (lock_q != LOCK_ERASED);
  assign rsv        = (I_REQ.addr >= RSV_BASE);
  assign on_lock_pg = (I_REQ.addr[ADDR_W-1:PAGE_BITS] == LOCK_ADDR[ADDR_W-1:PAGE_BITS]);
  assign take       = I_REQ_VALID & ready_q;
  // Modify command just sent; flash busy not yet visible
  assign mod_pend   = fcmd_q.valid & (fcmd_q.kind != FL_READ);

  // Classify and judge the request
  always_comb begin
    req_dbg  = 1'b0;
    flash_op = 1'b1;
    is_wr    = 1'b0;
    is_er    = 1'b0;
    is_dev   = 1'b0;
    fl_kind  = FL_READ;
    case (I_REQ.op)
      OP_CODE_READ: begin
        fl_kind = FL_READ;
      end
      OP_EXT_READ: begin
        flash_op = 1'b0;
      end
      OP_EXT_WRITE: begin
        flash_op = swe_q;
        is_er    = swe_q & see_q;
        is_wr    = swe_q & ~see_q;
        fl_kind  = see_q ? FL_PAGE_ERASE : FL_WRITE;
      end
      OP_DBG_READ: begin
        req_dbg = 1'b1;
      end
      OP_DBG_WRITE: begin
        req_dbg = 1'b1;
        is_wr   = 1'b1;
        fl_kind = FL_WRITE;
      end
      OP_DBG_ERASE: begin
        req_dbg = 1'b1;
        is_er   = 1'b1;
        fl_kind = FL_PAGE_ERASE;
      end
      OP_DBG_DEV_ERASE: begin
        req_dbg = 1'b1;
        is_dev  = 1'b1;
        fl_kind = FL_DEV_ERASE;
      end
      default: begin
        flash_op = 1'b0;
      end
    endcase
    fw_locked = ~req_dbg & page_locked(I_PC, lock_q);
    if (is_dev || !flash_op) begin
      bad = 1'b0;
    end else if (rsv) begin
      bad = 1'b1;
    end else if (is_er && on_lock_pg) begin
      bad = ~req_dbg | any_locked;
    end else if (is_wr && I_REQ.addr == LOCK_ADDR && lock_cur_q != LOCK_ERASED) begin
      bad = 1'b1;
    end else begin
      bad = page_locked(I_REQ.addr, lock_q) & ~fw_locked;
    end
  end

  assign need_key = flash_op & ~req_dbg & (is_wr | is_er);
  assign key_ok   = ~need_key | (key_q == KEY_OPEN);
  assign issue    = take & flash_op & ~bad & key_ok;
  assign err_now  = take & flash_op & bad & ~req_dbg;

  // Request path outputs
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      fcmd_q <= '0;
      external_data_ram_q <= '0;
      drop_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      fcmd_q.valid <= issue;
      fcmd_q.kind  <= fl_kind;
      fcmd_q.addr  <= is_er ? {I_REQ.addr[ADDR_W-1:PAGE_BITS], {PAGE_BITS{1'b0}}}
                            : I_REQ.addr;
      fcmd_q.data  <= I_REQ.data;
      external_data_ram_q.rd    <= take & (I_REQ.op == OP_EXT_READ);
      external_data_ram_q.wr    <= take & (I_REQ.op == OP_EXT_WRITE) & ~swe_q;
      external_data_ram_q.addr  <= I_REQ.addr;
      external_data_ram_q.data  <= I_REQ.data;
      drop_q       <= take & flash_op & ((bad & req_dbg) | (~bad & ~key_ok));
      err_q        <= err_now;
    end
  end

  // Acceptance; nothing more is taken once an error reset is requested
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      sampled_q <= 1'b0;
      halt_q    <= 1'b0;
      ready_q   <= 1'b0;
    end else begin
      sampled_q <= 1'b1;
      halt_q    <= halt_q | err_now;
      ready_q   <= sampled_q & ~halt_q & ~err_now & ~I_FL_BUSY & ~take & ~mod_pend;
    end
  end

  // Lock state taken once after reset release
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      lock_q <= LOCK_ERASED;
    end else if (!sampled_q) begin
      lock_q <= I_LOCK_BYTE;
    end
  end

  // Shadow of the lock byte as it now stands in flash
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      lock_cur_q <= LOCK_ERASED;
    end else if (!sampled_q) begin
      lock_cur_q <= I_LOCK_BYTE;
    end else if (issue && (is_dev || (is_er && on_lock_pg))) begin
      lock_cur_q <= LOCK_ERASED;
    end else if (issue && is_wr && I_REQ.addr == LOCK_ADDR) begin
      lock_cur_q <= lock_cur_q & I_REQ.data;
    end
  end

  // Interrupt hold during write or erase
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      irq_hold_q <= 1'b0;
    end else begin
      irq_hold_q <= I_FL_BUSY | mod_pend | (issue & (is_wr | is_er | is_dev));
    end
  end

  // APB handshake
  assign apb_acc = I_PSEL & I_PENABLE & ~pready_q;
  assign apb_wr  = I_PSEL & I_PENABLE & pready_q & I_PWRITE;

  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    case (I_PADDR)
      OFS_PROG_STORE_CTL: begin
        rd_mux[BIT_STORE_WRITE_EN] = swe_q;
        rd_mux[BIT_STORE_ERASE_EN] = see_q;
      end
      OFS_LOCK_KEY: begin
        rd_mux[1:0] = key_q;
      end
      OFS_RESET_SOURCE: begin
        rd_mux[BIT_POWER_ON_FLAG]  = por_q;
        rd_mux[BIT_FLASH_ERR_FLAG] = ferr_q;
      end
      OFS_LOCK_STATUS: begin
        rd_mux[7:0]            = lock_q;
        rd_mux[15:8]           = lock_cur_q;
        rd_mux[BIT_ANY_LOCKED] = any_locked;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= apb_acc;
      pslverr_q <= apb_acc & ~mapped;
      if (apb_acc) begin
        prdata_q <= I_PWRITE ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Program store control
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      swe_q <= RST_STORE_WRITE_EN;
      see_q <= RST_STORE_ERASE_EN;
    end else if (apb_wr && I_PADDR == OFS_PROG_STORE_CTL) begin
      swe_q <= I_PWDATA[BIT_STORE_WRITE_EN];
      see_q <= I_PWDATA[BIT_STORE_ERASE_EN];
    end
  end

  // Key sequencer; a firmware write or erase consumes the key
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      key_q <= KEY_IDLE;
    end else if (take && flash_op && !bad && need_key) begin
      key_q <= (key_q == KEY_OPEN) ? KEY_IDLE : KEY_DEAD;
    end else if (apb_wr && I_PADDR == OFS_LOCK_KEY) begin
      case (key_q)
        KEY_IDLE: key_q <= (I_PWDATA[7:0] == KEY_FIRST) ? KEY_HALF : KEY_DEAD;
        KEY_HALF: key_q <= (I_PWDATA[7:0] == KEY_SECOND) ? KEY_OPEN : KEY_DEAD;
        default:  key_q <= KEY_DEAD;
      endcase
    end
  end

  // Reset source flags survive the device reset; set wins over clear
  always_ff @(posedge I_CLK) begin
    if (!I_POR_N) begin
      por_q  <= 1'b1;
      ferr_q <= 1'b0;
    end else begin
      if (apb_wr && I_PADDR == OFS_RESET_SOURCE && I_PWDATA[BIT_POWER_ON_FLAG]) begin
        por_q <= 1'b0;
      end
      if (err_now) begin
        ferr_q <= 1'b1;
      end else if (apb_wr && I_PADDR == OFS_RESET_SOURCE && I_PWDATA[BIT_FLASH_ERR_FLAG]) begin
        ferr_q <= 1'b0;
      end
    end
  end

  assign O_PRDATA    = prdata_q;
  assign O_PREADY    = pready_q;
  assign O_PSLVERR   = pslverr_q;
  assign O_REQ_READY = ready_q;
  assign O_FL_CMD    = fcmd_q;
  assign O_EXTERNAL_DATA_RAM      = external_data_ram_q;
  assign O_DROP      = drop_q;
  assign O_ERR_RESET = err_q;
  assign O_IRQ_HOLD  = irq_hold_q;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  chk_ext_read_ram: assert property (
    take && I_REQ.op == OP_EXT_READ |=> O_EXTERNAL_DATA_RAM.rd && !O_FL_CMD.valid)
    else $error("external move read reached flash");

  chk_write_enable: assert property (
    take && I_REQ.op == OP_EXT_WRITE && !swe_q |=> O_EXTERNAL_DATA_RAM.wr && !O_FL_CMD.valid)
    else $error("flash modified without store write enable");

  chk_erase_enables: assert property (
    take && I_REQ.op == OP_EXT_WRITE && !(swe_q && see_q) |=>
    !(O_FL_CMD.valid && O_FL_CMD.kind == FL_PAGE_ERASE))
    else $error("software erase without both enables");

  chk_lock_count: assert property (
    take && req_dbg && !is_dev && !rsv && !on_lock_pg &&
    8'(I_REQ.addr[ADDR_W-1:PAGE_BITS]) < ~lock_q |=> O_DROP && !O_FL_CMD.valid)
    else $error("debug access to counted locked page not dropped");

  chk_fw_lock_erase: assert property (
    take && !req_dbg && is_er && on_lock_pg |=> O_ERR_RESET && !O_FL_CMD.valid)
    else $error("firmware erase of lock page not faulted");

  chk_err_halts: assert property (
    O_ERR_RESET |-> ferr_q ##1 (!O_REQ_READY && !O_FL_CMD.valid) [*4])
    else $error("error reset without flag or with later activity");

  chk_dbg_no_reset: assert property (
    take && req_dbg |=> !O_ERR_RESET)
    else $error("debug request caused error reset");

  chk_dev_erase: assert property (
    take && I_REQ.op == OP_DBG_DEV_ERASE |=> O_FL_CMD.valid && O_FL_CMD.kind == FL_DEV_ERASE)
    else $error("device erase not issued");

  chk_lock_stable: assert property (
    sampled_q ##1 sampled_q |-> $stable(lock_q))
    else $error("lock state changed without reset");

  chk_irq_hold: assert property (
    I_FL_BUSY |=> O_IRQ_HOLD)
    else $error("interrupts not held during flash operation");

  chk_erase_align: assert property (
    O_FL_CMD.valid && O_FL_CMD.kind == FL_PAGE_ERASE |-> O_FL_CMD.addr[PAGE_BITS-1:0] == '0)
    else $error("page erase address not page aligned");

endmodule

/* File: testbench/fsg_flash_model.sv */
// Flash controller model that reports busy after each modify command
`timescale 1ns/100ps
module fsg_flash_model
  import fsg_pkg::*;
#(
  parameter int BUSY_CYC = 4
) (
  input  wire logic      i_clk,
  input  wire logic      i_resetn,
  input  wire fsg_fcmd_s i_cmd,
  output logic           o_busy
);
  logic [3:0] cnt_q;

  // Busy from the cycle after a write or erase command
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q <= 4'h0;
    end else if (i_cmd.valid && i_cmd.kind != FL_READ) begin
      cnt_q <= 4'(BUSY_CYC);
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign o_busy = (cnt_q != 4'h0);
endmodule

/* File: testbench/test_flash_security_access_guard.sv */
// Testbench for the flash security access guard
`timescale 1ns/100ps
module test_flash_security_access_guard;
  import fsg_pkg::*;

  logic              clk    = 1'b0;
  logic              rst_n  = 1'b0;
  logic              por_n  = 1'b0;
  logic              psel   = 1'b0;
  logic              pen    = 1'b0;
  logic              pwr    = 1'b0;
  logic [7:0]        paddr  = 8'h00;
  logic [7:0]        lock_b = 8'hFF;
  logic [31:0]       pwdata = 32'h0;
  logic [ADDR_W-1:0] pc     = 16'h1000;
  logic              req_v  = 1'b0;
  fsg_req_s          req    = '0;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              perr;
  logic              pready;
  logic              pslverr;
  logic              req_rdy;
  logic              busy;
  logic              drop;
  logic              err;
  logic              hold;
  fsg_fcmd_s         fcmd;
  fsg_external_data_ram_s         external_data_ram;
  int                miscompares     = 0;
  int                samples_checked = 0;

  always #5 clk = ~clk;

  fsg_access_guard dut_u (
    .I_CLK       (clk),
    .I_RESETN    (rst_n),
    .I_POR_N     (por_n),
    .I_PSEL      (psel),
    .I_PENABLE   (pen),
    .I_PWRITE    (pwr),
    .I_PADDR     (paddr),
    .I_PWDATA    (pwdata),
    .O_PRDATA    (prdata),
    .O_PREADY    (pready),
    .O_PSLVERR   (pslverr),
    .I_LOCK_BYTE (lock_b),
    .I_PC        (pc),
    .I_REQ_VALID (req_v),
    .I_REQ       (req),
    .O_REQ_READY (req_rdy),
    .I_FL_BUSY   (busy),
    .O_FL_CMD    (fcmd),
    .O_EXTERNAL_DATA_RAM      (external_data_ram),
    .O_DROP      (drop),
    .O_ERR_RESET (err),
    .O_IRQ_HOLD  (hold)
  );

  fsg_flash_model flash_u (
    .i_clk    (clk),
    .i_resetn (rst_n),
    .i_cmd    (fcmd),
    .o_busy   (busy)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rst(input logic [7:0] lb);
    @(posedge clk);
    rst_n  <= 1'b0;
    lock_b <= lb;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (!pready) begin
      @(posedge clk);
    end
    rd   = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic keys();
    apb(1'b1, OFS_LOCK_KEY, {24'h0, KEY_FIRST});
    apb(1'b1, OFS_LOCK_KEY, {24'h0, KEY_SECOND});
  endtask

  // Result code: error reset, drop, external RAM, flash command
  task automatic rq(input fsg_op_e op, input logic [15:0] a, input logic [3:0] exp);
    @(posedge clk);
    req_v <= 1'b1;
    req   <= '{op, a, 8'h5A};
    @(posedge clk);
    while (!req_rdy) begin
      @(posedge clk);
    end
    req_v <= 1'b0;
    #1;
    chk(32'({err, drop, external_data_ram.rd | external_data_ram.wr, fcmd.valid}), 32'(exp));
  endtask

  task automatic t_open();
    rst(8'hFF);
    apb(1'b0, OFS_RESET_SOURCE, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(perr), 32'h1);
    rq(OP_EXT_READ, 16'h0100, 4'h2);
    chk(32'(external_data_ram.addr), 32'h0100);
    rq(OP_EXT_WRITE, 16'h1000, 4'h2);
    rq(OP_DBG_READ, 16'h3DFF, 4'h1);
    rq(OP_DBG_READ, 16'h3E10, 4'h4);
    rq(OP_DBG_ERASE, 16'h3C00, 4'h1);
    apb(1'b1, OFS_PROG_STORE_CTL, 32'h1);
    keys();
    rq(OP_EXT_WRITE, 16'h1000, 4'h1);
    chk(32'(fcmd.kind), 32'(FL_WRITE));
    chk(32'(fcmd.data), 32'h5A);
    @(posedge clk);
    #1;
    chk(32'(hold), 32'h1);
    rq(OP_EXT_WRITE, 16'h1001, 4'h4);
    apb(1'b0, OFS_LOCK_KEY, 32'h0);
    chk(rd & 32'h3, 32'h3);
    rst(8'hFF);
    apb(1'b1, OFS_PROG_STORE_CTL, 32'h3);
    keys();
    rq(OP_EXT_WRITE, 16'h1234, 4'h1);
    chk(32'(fcmd.kind), 32'(FL_PAGE_ERASE));
    chk(32'(fcmd.addr), 32'h1200);
    keys();
    rq(OP_EXT_WRITE, 16'h3C05, 4'h8);
    apb(1'b0, OFS_RESET_SOURCE, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b1, OFS_RESET_SOURCE, 32'h2);
    apb(1'b0, OFS_RESET_SOURCE, 32'h0);
    chk(rd & 32'h3, 32'h1);
    $display("open test done");
  endtask

  task automatic t_locked();
    rst(8'hFD);
    apb(1'b0, OFS_LOCK_STATUS, 32'h0);
    chk(rd, 32'h0001FDFD);
    rq(OP_DBG_READ, 16'h0200, 4'h4);
    rq(OP_DBG_READ, 16'h0400, 4'h1);
    rq(OP_CODE_READ, 16'h0400, 4'h1);
    rq(OP_DBG_READ, 16'h3C00, 4'h4);
    rq(OP_DBG_WRITE, 16'h3DFF, 4'h4);
    rq(OP_DBG_ERASE, 16'h3C00, 4'h4);
    @(posedge clk);
    pc <= 16'h0100;
    rq(OP_CODE_READ, 16'h3DFF, 4'h1);
    rq(OP_DBG_DEV_ERASE, 16'h0000, 4'h1);
    chk(32'(fcmd.kind), 32'(FL_DEV_ERASE));
    apb(1'b0, OFS_LOCK_STATUS, 32'h0);
    chk(rd & 32'h000100FF, 32'h000100FD);
    @(posedge clk);
    pc <= 16'h1000;
    rq(OP_CODE_READ, 16'h0000, 4'h8);
    @(posedge clk);
    #1;
    chk(32'(req_rdy), 32'h0);
    $display("locked test done");
  endtask

  initial begin
    t_open();
    t_locked();
    stop_test();
  end

  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule
